// ===== iobtd_core.sv
// Purpose: Decoder and timing generator for programmed I/O and data
//          channel cycles on a peripheral I/O bus.
// Assumes: All pin inputs are asynchronous; one system clock.
// Notes:   Strobe outputs are decoded from registered state.
//
// Notes on behaviour
// - Start an I/O or channel cycle only while priority input is high.
// - Busy, done strobes and control decodes only while chip select high; channel cycles start, drive busy and reach done without it.
// - With response enable low, ignore every programmed I/O cycle.
// - Three-bit timing option code selects strobe timing of cycles.
// - Instruction bits 5 to 9, active low, decoded in address phase.
// - Reset pin pulled low initialises block and asserts peripheral reset.
// - Capacitive reset low drives the system reset pin low.
// - Read-switches, interrupt-on, auto-load and halt keep CPU timing.
// - Global/local select chooses the use of the console/status modes.
// - Data-in A/B/C, interrupt acknowledge, skip strobes pulse low.
// - Data-out A/B/C pulse low, mask-out pulses high on outputs.
// - Peripheral reset low on I/O reset instruction or system reset.
// - Start, clear, pulse outputs go low, decoded and timed.
// - Device select enable goes low to allow device selection.
// - I/O execute output held low throughout a programmed I/O cycle.
// - Others drive busy low; block drives it before and during cycles.
// - Channel execute held low while a channel transfer runs.
// - Channel address strobe pulses low in address transfer time.
// - Channel-in strobe pulses low during transfer into memory.
// - State counter advances on every second rising clock-input edge; with timing code zero it advances every system clock.
// - Channel-out strobe pulses low during transfer to the peripheral.
`timescale 1ns/10ps
`default_nettype none
module iobtd_core (
  input  wire logic       sys_clk,              // System clock, 40 MHz.
  input  wire logic       reset_n,              // Sync reset, active low.
  input  wire logic       clk_in,               // Timing clock pin.
  input  wire logic       cycle_priority_in,    // Priority, high.
  input  wire logic       ctrl_chip_select,     // Chip select, high.
  input  wire logic       cpu_class_select_n,   // Device 77 decode.
  input  wire logic       pio_response_enable,  // I/O enable, high.
  input  wire logic       channel_request_n,    // Channel request.
  input  wire logic [2:0] timing_option_code,   // Timing option.
  input  wire logic [4:0] instr_field_bits,     // Bits 5..9, low.
  input  wire logic       pio_cycle_req,        // CPU I/O address phase.
  input  wire logic       channel_dir_out,      // Channel output mode.
  input  wire logic       global_local_sel,     // Global/local select.
  input  wire logic       cap_reset_in,         // Capacitor reset, low.
  input  wire logic       system_reset_pin_in,  // Reset pin level.
  output logic            system_reset_pin_out, // Reset pin value.
  output logic            system_reset_pin_oe,  // Reset pin drive.
  input  wire logic       shared_bus_busy_in,   // Busy line level.
  output logic            shared_bus_busy_out,  // Busy line value.
  output logic            shared_bus_busy_oe,   // Busy line drive.
  output logic            pio_ready,            // CPU may continue.
  output logic            peripheral_reset_out, // I/O reset, low.
  output logic            data_in_a_strobe,     // Low pulse.
  output logic            data_in_b_strobe,     // Low pulse.
  output logic            data_in_c_strobe,     // Low pulse.
  output logic            int_ack_strobe,       // Low pulse.
  output logic            skip_test_strobe,     // Low pulse.
  output logic            data_out_a_strobe,    // Low pulse.
  output logic            data_out_b_strobe,    // Low pulse.
  output logic            data_out_c_strobe,    // Low pulse.
  output logic            mask_out_strobe,      // High pulse.
  output logic            start_strobe_n,       // Start, low.
  output logic            clear_strobe_n,       // Clear, low.
  output logic            pulse_strobe_n,       // Pulse, low.
  output logic            dev_select_enable,    // Select enable, low.
  output logic            pio_execute_n,        // I/O execute, low.
  output logic            channel_xfer_active,  // Channel exec, low.
  output logic            channel_addr_strobe,  // Address, low.
  output logic            channel_in_strobe,    // Into memory, low.
  output logic            channel_out_strobe    // To peripheral, low.
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  logic [iobtd_pkg::SYNC_W-1:0] pins;
  logic [iobtd_pkg::SYNC_W-1:0] s;

  assign pins = {channel_dir_out, shared_bus_busy_in, pio_cycle_req,
                 clk_in, global_local_sel, cap_reset_in,
                 system_reset_pin_in, instr_field_bits,
                 timing_option_code, channel_request_n,
                 pio_response_enable, cpu_class_select_n,
                 ctrl_chip_select, cycle_priority_in};

  iobtd_sync #(
    .W    (iobtd_pkg::SYNC_W),
    .INIT (iobtd_pkg::SYNC_INIT)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .pin_in   (pins),
    .sync_out (s)
  );

  logic       pri_s, cs_s, cpu77_s, ena_s, chreq_s, rpin_s, cap_s;
  logic       glob_s, clkin_s, preq_s, busy_s, dir_s;
  logic [2:0] topt_s;
  logic [4:0] instr_s;

  assign pri_s   = s[iobtd_pkg::SI_PRI];
  assign cs_s    = s[iobtd_pkg::SI_CS];
  assign cpu77_s = ~s[iobtd_pkg::SI_CPU_N];
  assign ena_s   = s[iobtd_pkg::SI_ENA];
  assign chreq_s = ~s[iobtd_pkg::SI_CHR_N];
  assign topt_s  = s[iobtd_pkg::SI_TOPT +: 3];
  assign instr_s = ~s[iobtd_pkg::SI_INSTR +: 5];
  assign rpin_s  = ~s[iobtd_pkg::SI_RPIN];
  assign cap_s   = ~s[iobtd_pkg::SI_CAP];
  assign glob_s  = s[iobtd_pkg::SI_GLOB];
  assign clkin_s = s[iobtd_pkg::SI_CLKIN];
  assign preq_s  = s[iobtd_pkg::SI_PREQ];
  assign busy_s  = ~s[iobtd_pkg::SI_BUSY];
  assign dir_s   = s[iobtd_pkg::SI_DIR];

  ////////////////////////////////////////////////////////////////////////
  // Reset handling. The pin is open drain, so it is only pulled low.

  logic rst_int;

  assign system_reset_pin_out = 1'b0;
  assign system_reset_pin_oe  = cap_s;
  assign rst_int = !reset_n || rpin_s;

  ////////////////////////////////////////////////////////////////////////
  // State counter on the timing clock input.

  logic clkin_d_q;
  logic half_q;
  logic sc_tick;
  logic [2:0] topt_q;

  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      clkin_d_q <= 1'b0;
      half_q    <= 1'b0;
    end else begin
      clkin_d_q <= clkin_s;
      if (clkin_s && !clkin_d_q) begin
        half_q <= !half_q;
      end
    end
  end

  // Native code ticks every system clock; others use the counter.
  assign sc_tick = (topt_q == iobtd_pkg::TOPT_NATIVE) ||
                   (clkin_s && !clkin_d_q && half_q);

  ////////////////////////////////////////////////////////////////////////
  // Cycle start decision.

  iobtd_pkg::iobtd_state_e state_q;
  logic       is_pio_q;
  logic       dir_q;
  logic [2:0] fn_q;
  logic [1:0] cf_q;
  logic       dev77_q;
  logic [3:0] cnt_q;
  logic       other_busy;
  logic       pio_go;
  logic       dch_go;
  logic       d77;
  logic       keep_timing;

  assign other_busy = busy_s && !shared_bus_busy_oe;
  // Device 77 instructions belong to this block only in global use.
  assign d77 = cpu77_s && glob_s;
  assign pio_go = preq_s && ena_s && cs_s;
  assign dch_go = chreq_s && !preq_s;
  // These CPU-class instructions run at processor speed, unstretched.
  assign keep_timing = d77 &&
    (instr_s[4:2] == iobtd_pkg::FN_IN_A ||
     instr_s[4:2] == iobtd_pkg::FN_OUT_A ||
     instr_s[4:2] == iobtd_pkg::FN_OUT_C ||
     (instr_s[4:2] == iobtd_pkg::FN_NIO &&
      instr_s[1:0] == iobtd_pkg::CF_START));

  ////////////////////////////////////////////////////////////////////////
  // Cycle sequencer.

  logic [3:0] phase_len;

  always_comb begin
    unique case (state_q)
      iobtd_pkg::ST_SETUP: phase_len = iobtd_pkg::SETUP_TICKS[topt_q];
      iobtd_pkg::ST_HOLD:  phase_len = iobtd_pkg::HOLD_TICKS[topt_q];
      default:             phase_len = iobtd_pkg::STROBE_TICKS[topt_q];
    endcase
  end

  logic phase_end;
  assign phase_end = sc_tick && (cnt_q == phase_len - 4'h1);

  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      state_q <= iobtd_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      unique case (state_q)
        iobtd_pkg::ST_IDLE: begin
          cnt_q <= 4'h0;
          if (pri_s && !other_busy) begin
            if (pio_go && keep_timing) begin
              state_q <= iobtd_pkg::ST_WAIT;
            end else if (pio_go || dch_go) begin
              state_q <= iobtd_pkg::ST_CLAIM;
            end
          end
        end
        iobtd_pkg::ST_CLAIM: begin
          state_q <= iobtd_pkg::ST_SETUP;
        end
        iobtd_pkg::ST_SETUP, iobtd_pkg::ST_ADDR,
        iobtd_pkg::ST_DATA, iobtd_pkg::ST_HOLD: begin
          if (phase_end) begin
            cnt_q <= 4'h0;
            unique case (state_q)
              iobtd_pkg::ST_SETUP: state_q <= is_pio_q ?
                iobtd_pkg::ST_DATA : iobtd_pkg::ST_ADDR;
              iobtd_pkg::ST_ADDR:  state_q <= iobtd_pkg::ST_DATA;
              iobtd_pkg::ST_DATA:  state_q <= iobtd_pkg::ST_HOLD;
              default:             state_q <= iobtd_pkg::ST_WAIT;
            endcase
          end else if (sc_tick) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        iobtd_pkg::ST_WAIT: begin
          // A held request must not start a second cycle.
          if (is_pio_q ? !preq_s : !chreq_s) begin
            state_q <= iobtd_pkg::ST_IDLE;
          end
        end
        default: state_q <= iobtd_pkg::ST_IDLE;
      endcase
    end
  end

  // Cycle attributes are frozen at the start, in the address phase.
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      is_pio_q <= 1'b0;
      dir_q    <= 1'b0;
      topt_q   <= iobtd_pkg::TOPT_NATIVE;
      fn_q     <= iobtd_pkg::FN_NIO;
      cf_q     <= iobtd_pkg::CF_NONE;
      dev77_q  <= 1'b0;
    end else if (state_q == iobtd_pkg::ST_IDLE) begin
      is_pio_q <= pio_go;
      dir_q    <= dir_s;
      topt_q   <= topt_s;
      fn_q     <= instr_s[4:2];
      cf_q     <= instr_s[1:0];
      dev77_q  <= d77;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  logic active;
  logic pio_str;
  logic dch_str;

  assign active  = state_q inside {iobtd_pkg::ST_CLAIM,
                   iobtd_pkg::ST_SETUP, iobtd_pkg::ST_ADDR,
                   iobtd_pkg::ST_DATA, iobtd_pkg::ST_HOLD};
  assign pio_str = is_pio_q && cs_s && state_q == iobtd_pkg::ST_DATA;
  assign dch_str = !is_pio_q && state_q == iobtd_pkg::ST_DATA;

  assign shared_bus_busy_out = 1'b0;
  assign shared_bus_busy_oe  = active;
  assign pio_ready           = state_q == iobtd_pkg::ST_WAIT;
  assign pio_execute_n       = !(active && is_pio_q);
  assign dev_select_enable   = !(active && is_pio_q &&
                                 state_q != iobtd_pkg::ST_CLAIM);
  assign channel_xfer_active = !(active && !is_pio_q);
  assign channel_addr_strobe = !(state_q == iobtd_pkg::ST_ADDR);
  assign channel_in_strobe   = !(dch_str && !dir_q);
  assign channel_out_strobe  = !(dch_str && dir_q);

  assign data_in_a_strobe  = !(pio_str && !dev77_q &&
                               fn_q == iobtd_pkg::FN_IN_A);
  assign data_in_b_strobe  = !(pio_str && !dev77_q &&
                               fn_q == iobtd_pkg::FN_IN_B);
  assign data_in_c_strobe  = !(pio_str && !dev77_q &&
                               fn_q == iobtd_pkg::FN_IN_C);
  assign int_ack_strobe    = !(pio_str && dev77_q &&
                               fn_q == iobtd_pkg::FN_IN_B);
  assign skip_test_strobe  = !(pio_str &&
                               fn_q == iobtd_pkg::FN_SKIP);
  assign data_out_a_strobe = !(pio_str && !dev77_q &&
                               fn_q == iobtd_pkg::FN_OUT_A);
  assign data_out_b_strobe = !(pio_str && !dev77_q &&
                               fn_q == iobtd_pkg::FN_OUT_B);
  assign data_out_c_strobe = !(pio_str && !dev77_q &&
                               fn_q == iobtd_pkg::FN_OUT_C);
  assign mask_out_strobe   = pio_str && dev77_q &&
                             fn_q == iobtd_pkg::FN_OUT_B;

  assign start_strobe_n = !(pio_str && !dev77_q &&
                            cf_q == iobtd_pkg::CF_START);
  assign clear_strobe_n = !(pio_str && !dev77_q &&
                            cf_q == iobtd_pkg::CF_CLEAR);
  assign pulse_strobe_n = !(pio_str && !dev77_q &&
                            cf_q == iobtd_pkg::CF_PULSE);

  assign peripheral_reset_out = !(rpin_s || cap_s || !reset_n ||
    (pio_str && dev77_q && fn_q == iobtd_pkg::FN_IN_C));

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n || rpin_s);

  sequence s_idle_start;
    state_q == iobtd_pkg::ST_IDLE ##1 state_q == iobtd_pkg::ST_CLAIM;
  endsequence

  sequence s_dch_addr;
    !channel_xfer_active && !channel_addr_strobe;
  endsequence

  chk_start_priority: assert property (s_idle_start |->
    $past(pri_s, 1)) else $error("cycle started without priority");
  chk_start_not_busy: assert property (s_idle_start |->
    !$past(other_busy, 1)) else $error("cycle started while bus busy");
  chk_enable_blocks: assert property (
    (state_q == iobtd_pkg::ST_IDLE && !ena_s && !dch_go) |=>
    state_q == iobtd_pkg::ST_IDLE) else $error("pio taken while disabled");
  chk_cs_gates: assert property (!cs_s |->
    data_in_a_strobe && data_out_a_strobe && start_strobe_n)
    else $error("strobe without chip select");
  chk_busy_claim: assert property (
    (!pio_execute_n || !channel_xfer_active) |-> shared_bus_busy_oe)
    else $error("cycle without busy drive");
  chk_exec_span: assert property (s_idle_start ##0 is_pio_q |->
    !pio_execute_n [*2]) else $error("execute dropped early");
  chk_chan_order: assert property ($fell(channel_addr_strobe) |->
    s_dch_addr [*1] ##[1:400] state_q == iobtd_pkg::ST_DATA)
    else $error("channel data phase not after address");
  chk_strobe_width: assert property (
    state_q == iobtd_pkg::ST_DATA |->
    cnt_q < iobtd_pkg::STROBE_TICKS[topt_q])
    else $error("strobe longer than timing code");
  chk_cap_pin: assert property (cap_s |-> system_reset_pin_oe &&
    !peripheral_reset_out) else $error("capacitor reset not driven");
  chk_half_rate: assert property (
    (topt_q != iobtd_pkg::TOPT_NATIVE && sc_tick) |=> !sc_tick)
    else $error("state counter ticked twice in a row");

endmodule : iobtd_core
`default_nettype wire

// ===== iobtd_core_bench.sv
// Purpose: Self-checking bench for the I/O bus timing decoder.
// Assumes: clk_in runs at 8 clocks a period, so one tick is 16 clocks.
// Notes:   Open-drain lines are resolved here with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module iobtd_core_bench;
  logic sys_clk = 0, reset_n = 0, clk_in = 0, cycle_priority_in = 1;
  logic ctrl_chip_select = 1, cpu_class_select_n = 1, cap_reset_in = 1;
  logic pio_response_enable = 1, global_local_sel = 1;
  logic [2:0] timing_option_code = 3'h0;
  logic pio_cycle_req, channel_request_n, channel_dir_out, pio_ready;
  logic [4:0] instr_field_bits;
  logic system_reset_pin_in, system_reset_pin_out, system_reset_pin_oe;
  logic shared_bus_busy_in, shared_bus_busy_out, shared_bus_busy_oe;
  logic peripheral_reset_out, data_in_a_strobe, data_in_b_strobe;
  logic data_in_c_strobe, int_ack_strobe, skip_test_strobe;
  logic data_out_a_strobe, data_out_b_strobe, data_out_c_strobe;
  logic mask_out_strobe, start_strobe_n, clear_strobe_n, pulse_strobe_n;
  logic dev_select_enable, pio_execute_n, channel_xfer_active;
  logic channel_addr_strobe, channel_in_strobe, channel_out_strobe;
  logic pin_pull = 0, foreign_busy = 0, mon = 0, bad_order = 0;
  logic [19:0] seen = '0;
  int failures = 0, n_checks = 0, low_len = 0;
  bit ok;
  typedef struct {logic d77; int kind; logic [4:0] ib; logic [19:0] e;}
    iobtd_row_s;
  iobtd_row_s rows [15] = '{
    '{0, 0, 5'h1B, 20'h8_0070}, '{0, 0, 5'h13, 20'h4_0070},
    '{0, 0, 5'h0B, 20'h2_0070}, '{0, 0, 5'h17, 20'h0_4070},
    '{0, 0, 5'h0F, 20'h0_2070}, '{0, 0, 5'h07, 20'h0_1070},
    '{0, 0, 5'h03, 20'h0_8070}, '{0, 0, 5'h1E, 20'h0_0870},
    '{0, 0, 5'h1D, 20'h0_0470}, '{0, 0, 5'h1C, 20'h0_0270},
    '{1, 0, 5'h13, 20'h1_0070}, '{1, 0, 5'h0F, 20'h0_00F0},
    '{1, 0, 5'h0B, 20'h0_0170}, '{0, 1, 5'h1F, 20'h0_001D},
    '{0, 2, 5'h1F, 20'h0_001B}};
  logic [4:0] fast [4] = '{5'h1B, 5'h17, 5'h07, 5'h1E};
  wire logic [19:0] act = {~data_in_a_strobe, ~data_in_b_strobe,
    ~data_in_c_strobe, ~int_ack_strobe, ~skip_test_strobe,
    ~data_out_a_strobe, ~data_out_b_strobe, ~data_out_c_strobe,
    ~start_strobe_n, ~clear_strobe_n, ~pulse_strobe_n,
    ~peripheral_reset_out, mask_out_strobe, ~pio_execute_n,
    ~dev_select_enable, ~shared_bus_busy_in, ~channel_addr_strobe,
    ~channel_in_strobe, ~channel_out_strobe, ~channel_xfer_active};
  assign system_reset_pin_in =
    ~(pin_pull | (system_reset_pin_oe & ~system_reset_pin_out));
  assign shared_bus_busy_in =
    ~(foreign_busy | (shared_bus_busy_oe & ~shared_bus_busy_out));
  iobtd_core iobtd_core_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_in(clk_in),
    .cycle_priority_in(cycle_priority_in),
    .ctrl_chip_select(ctrl_chip_select),
    .cpu_class_select_n(cpu_class_select_n),
    .pio_response_enable(pio_response_enable),
    .channel_request_n(channel_request_n),
    .timing_option_code(timing_option_code),
    .instr_field_bits(instr_field_bits), .pio_cycle_req(pio_cycle_req),
    .channel_dir_out(channel_dir_out),
    .global_local_sel(global_local_sel), .cap_reset_in(cap_reset_in),
    .system_reset_pin_in(system_reset_pin_in),
    .system_reset_pin_out(system_reset_pin_out),
    .system_reset_pin_oe(system_reset_pin_oe),
    .shared_bus_busy_in(shared_bus_busy_in),
    .shared_bus_busy_out(shared_bus_busy_out),
    .shared_bus_busy_oe(shared_bus_busy_oe), .pio_ready(pio_ready),
    .peripheral_reset_out(peripheral_reset_out),
    .data_in_a_strobe(data_in_a_strobe),
    .data_in_b_strobe(data_in_b_strobe),
    .data_in_c_strobe(data_in_c_strobe), .int_ack_strobe(int_ack_strobe),
    .skip_test_strobe(skip_test_strobe),
    .data_out_a_strobe(data_out_a_strobe),
    .data_out_b_strobe(data_out_b_strobe),
    .data_out_c_strobe(data_out_c_strobe),
    .mask_out_strobe(mask_out_strobe), .start_strobe_n(start_strobe_n),
    .clear_strobe_n(clear_strobe_n), .pulse_strobe_n(pulse_strobe_n),
    .dev_select_enable(dev_select_enable), .pio_execute_n(pio_execute_n),
    .channel_xfer_active(channel_xfer_active),
    .channel_addr_strobe(channel_addr_strobe),
    .channel_in_strobe(channel_in_strobe),
    .channel_out_strobe(channel_out_strobe));
  iobtd_cpu_model iobtd_cpu_model_inst (
    .sys_clk(sys_clk), .pio_ready(pio_ready),
    .pio_cycle_req(pio_cycle_req), .instr_field_bits(instr_field_bits),
    .channel_request_n(channel_request_n),
    .channel_dir_out(channel_dir_out));
  always #12.5 sys_clk = ~sys_clk;
  always #100 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (mon) begin
      seen <= seen | act;
      if (data_out_a_strobe === 1'b0) low_len <= low_len + 1;
      if ((act[2] | act[1]) && (act[3] | !seen[3])) bad_order <= 1'b1;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic go(input int kind, input logic [4:0] ib, input int lim);
    @(negedge sys_clk);
    seen = '0;
    low_len = 0;
    bad_order = 0;
    mon = 1;
    iobtd_cpu_model_inst.run(kind, ib, lim, ok);
    repeat (8) @(negedge sys_clk);
    mon = 0;
  endtask : go
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    failures++;
    final_report();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    check(peripheral_reset_out, 1'b0, "reset output in reset");
    reset_n = 1;
    repeat (4) @(negedge sys_clk);
    check(peripheral_reset_out, 1'b1, "reset output after");
    foreach (rows[i]) begin
      cpu_class_select_n = ~rows[i].d77;
      go(rows[i].kind, rows[i].ib, 200);
      check(ok, 1'b1, "cycle end");
      check(seen, rows[i].e, "strobes");
      check(bad_order, 1'b0, "channel order");
    end
    // The fast instructions are only fast as device 77 instructions.
    cpu_class_select_n = 0;
    foreach (fast[i]) begin
      go(0, fast[i], 6);
      check(ok, 1'b1, "fast instruction");
    end
    global_local_sel = 0;
    go(0, 5'h0F, 200);
    check(seen, 20'h0_2070, "global off");
    global_local_sel = 1;
    cpu_class_select_n = 1;
    for (int k = 0; k < 4; k++) begin
      cycle_priority_in = (k != 0);
      ctrl_chip_select = (k != 1);
      pio_response_enable = (k != 2);
      foreign_busy = (k == 3);
      go(0, 5'h17, 30);
      check(ok, 1'b0, "refused");
      check(seen[19:5], 15'h0, "no strobe");
    end
    cycle_priority_in = 1;
    ctrl_chip_select = 1;
    pio_response_enable = 1;
    foreign_busy = 0;
    for (int c = 0; c < 8; c++) begin
      timing_option_code = c[2:0];
      go(0, 5'h17, 400);
      check(low_len, c == 0 ? 2 : 16 * iobtd_pkg::STROBE_TICKS[c],
            "strobe length");
    end
    cap_reset_in = 0;
    repeat (4) @(negedge sys_clk);
    check(system_reset_pin_in, 1'b0, "pin driven");
    check(peripheral_reset_out, 1'b0, "cap reset");
    cap_reset_in = 1;
    repeat (6) @(negedge sys_clk);
    pin_pull = 1;
    repeat (4) @(negedge sys_clk);
    check(system_reset_pin_oe, 1'b0, "pin not driven");
    check(peripheral_reset_out, 1'b0, "pin reset");
    pin_pull = 0;
    repeat (6) @(negedge sys_clk);
    go(0, 5'h17, 400);
    check(seen, 20'h0_4070, "after reset");
    final_report();
  end
endmodule : iobtd_core_bench
`default_nettype wire

// ===== iobtd_cpu_model.sv
// Purpose: CPU side model that issues I/O and channel cycles.
// Assumes: Requests change only at the falling clock edge.
// Notes:   Released fields show the inverse of their last value.
`timescale 1ns/10ps
`default_nettype none
module iobtd_cpu_model (
  input  wire logic       sys_clk,           // System clock.
  input  wire logic       pio_ready,         // Cycle finished.
  output logic            pio_cycle_req,     // I/O address phase.
  output logic [4:0]      instr_field_bits,  // Bits 5..9, low.
  output logic            channel_request_n, // Channel request.
  output logic            channel_dir_out    // Channel to peripheral.
);
  initial begin
    pio_cycle_req = 1'b0;
    instr_field_bits = 5'h1F;
    channel_request_n = 1'b1;
    channel_dir_out = 1'b0;
  end
  // Kind 0 is an I/O instruction, 1 a channel input, 2 a channel output.
  task automatic run(input int kind, input logic [4:0] ib,
                     input int limit, output bit ok);
    int n;
    @(negedge sys_clk);
    instr_field_bits = ib;
    channel_dir_out = (kind == 2);
    if (kind == 0) pio_cycle_req = 1'b1;
    else channel_request_n = 1'b0;
    n = 0;
    ok = 0;
    while (!ok && n < limit) begin
      @(posedge sys_clk);
      ok = (pio_ready === 1'b1);
      n++;
    end
    @(negedge sys_clk);
    pio_cycle_req = 1'b0;
    channel_request_n = 1'b1;
    instr_field_bits = ~ib;
  endtask : run
endmodule : iobtd_cpu_model
`default_nettype wire

// ===== iobtd_pkg.sv
// Purpose: Shared constants for the I/O bus timing decoder.
// Assumes: One 40 MHz system clock; all pins arrive asynchronously.
// Notes:   Tick tables are indexed by the three-bit timing option code.
package iobtd_pkg;

  // Index of each pin in the synchroniser vector.
  localparam int unsigned SI_PRI   = 0;
  localparam int unsigned SI_CS    = 1;
  localparam int unsigned SI_CPU_N = 2;
  localparam int unsigned SI_ENA   = 3;
  localparam int unsigned SI_CHR_N = 4;
  localparam int unsigned SI_TOPT  = 5;
  localparam int unsigned SI_INSTR = 8;
  localparam int unsigned SI_RPIN  = 13;
  localparam int unsigned SI_CAP   = 14;
  localparam int unsigned SI_GLOB  = 15;
  localparam int unsigned SI_CLKIN = 16;
  localparam int unsigned SI_PREQ  = 17;
  localparam int unsigned SI_BUSY  = 18;
  localparam int unsigned SI_DIR   = 19;
  localparam int unsigned SYNC_W   = 20;

  // Idle levels of the pins, loaded into the synchroniser at reset.
  localparam logic [SYNC_W-1:0] SYNC_INIT = 20'h4_FF14;

  // Transfer function field, instruction bits 5 to 7 after inversion.
  localparam logic [2:0] FN_NIO = 3'h0;
  localparam logic [2:0] FN_IN_A  = 3'h1;
  localparam logic [2:0] FN_OUT_A = 3'h2;
  localparam logic [2:0] FN_IN_B  = 3'h3;
  localparam logic [2:0] FN_OUT_B = 3'h4;
  localparam logic [2:0] FN_IN_C  = 3'h5;
  localparam logic [2:0] FN_OUT_C = 3'h6;
  localparam logic [2:0] FN_SKIP  = 3'h7;

  // Control field, instruction bits 8 and 9 after inversion.
  localparam logic [1:0] CF_NONE  = 2'h0;
  localparam logic [1:0] CF_START = 2'h1;
  localparam logic [1:0] CF_CLEAR = 2'h2;
  localparam logic [1:0] CF_PULSE = 2'h3;

  // Code zero is native timing: one tick per system clock.
  localparam logic [2:0] TOPT_NATIVE = 3'h0;

  // Ticks of setup, strobe and hold for each timing option code.
  localparam logic [3:0] SETUP_TICKS [8] =
    '{4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3};
  localparam logic [3:0] STROBE_TICKS [8] =
    '{4'h2, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6};
  localparam logic [3:0] HOLD_TICKS [8] =
    '{4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CLAIM,
    ST_SETUP,
    ST_ADDR,
    ST_DATA,
    ST_HOLD,
    ST_WAIT
  } iobtd_state_e;

endpackage : iobtd_pkg

// ===== iobtd_sync.sv
// Purpose: Two-flop synchroniser for a vector of asynchronous pins.
// Assumes: Bits are independent levels; no word is crossed here.
// Notes:   Reset loads the idle level so no false request appears.
`timescale 1ns/10ps
`default_nettype none
module iobtd_sync #(
  parameter int unsigned      W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  input  wire logic         sys_clk,  // System clock.
  input  wire logic         reset_n,  // Synchronous reset, active low.
  input  wire logic [W-1:0] pin_in,   // Asynchronous pin levels.
  output logic      [W-1:0] sync_out  // Levels after two flops.
);

  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
        meta_q[i]   <= INIT[i];
        sync_out[i] <= INIT[i];
      end else begin
        meta_q[i]   <= pin_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule : iobtd_sync
`default_nettype wire
